/* File: core/acc_regfile.sv */
// Purpose: accelerometer register file reached as a two-wire serial slave
// Assumes: SCL and SDA_I synchronous to CORE_CLK and far slower than it
// Notes: SDA is open drain; SDA_OE high pulls the line low
//
// Behaviour
// - write pointer advances after each data byte
// - burst write bytes acknowledged, stored until stop
// - axis high byte holds sample bits nine..two
// - axis low byte: two lsbs on top
// - reserved locations read as zero
// - config writable only in standby, two exceptions
// - standby to active clears data and status
// - active to standby keeps data and status
// - fast read skips axis low bytes
// - normal read walks all six axis bytes
// - stop condition ends every transfer
`timescale 1ns/1ps
`include "acc_i2c_map.svh"

module acc_regfile
  import acc_pkg::*;
#(
  parameter logic [7:0] IDENT_CODE = 8'h3c // arbitrary value, not a real part code
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire acc_sense_t SENSE,
  input wire logic SENSE_VALID,
  output acc_cfg_t CFG
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  acc_state_t state_q; // serial slave phase
  logic [3:0] cnt_q; // bit count inside a byte
  logic [7:0] sh_q; // shift register, in and out
  logic [7:0] ptr_q; // register pointer, kept across transfers
  logic rw_q; // direction of the addressed transfer
  logic mack_q; // master acknowledged the last read byte
  logic sda_oe_q; // pull sda low
  logic sda_o_q; // open drain level, always low
  logic scl_q; // previous scl sample
  logic sda_q; // previous sda sample
  logic act_prev_q; // active bit one cycle ago
  acc_sense_t data_q; // real-time data and event registers
  acc_cfg_t cfg_q; // configuration registers

  // configuration after reset or soft reset
  localparam acc_cfg_t CFG_RST = '{
    fs: `ACC_ZERO, or_cfg: `ACC_ORCFG_RST, or_db: `ACC_ZERO, md_cfg: `ACC_ZERO,
    md_ths: `ACC_ZERO, md_db: `ACC_ZERO, aslp: `ACC_ZERO, ctrl1: `ACC_ZERO,
    ctrl2: `ACC_ZERO, ctrl3: `ACC_ZERO, inten: `ACC_ZERO, intmap: `ACC_ZERO,
    offx: `ACC_ZERO, offy: `ACC_ZERO, offz: `ACC_ZERO};

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------
  // next pointer after a data byte; axis bytes and the last offset jump, reserved gaps after 0x0e and 0x18 are walked through
  function automatic logic [7:0] next_ptr(logic [7:0] a, logic fast);
    logic [7:0] n;
    n = a + 8'h01;
    if (a == `ACC_A_X_HI) n = fast ? `ACC_A_Y_HI : `ACC_A_X_LO;
    else if (a == `ACC_A_X_LO) n = fast ? `ACC_A_STATUS : `ACC_A_Y_HI;
    else if (a == `ACC_A_Y_HI) n = fast ? `ACC_A_Z_HI : `ACC_A_Y_LO;
    else if (a == `ACC_A_Y_LO) n = fast ? `ACC_A_STATUS : `ACC_A_Z_HI;
    else if (a == `ACC_A_Z_HI) n = fast ? `ACC_A_STATUS : `ACC_A_Z_LO;
    else if (a == `ACC_A_Z_LO) n = `ACC_A_STATUS; // last axis byte wraps
    else if (a == `ACC_A_OFFZ) n = `ACC_A_IDENT; // last offset wraps to identity
    else if (a > `ACC_A_OFFZ) n = `ACC_A_STATUS; // beyond the map: back to the start
    return n;
  endfunction

  // high byte of a sample
  function automatic logic [7:0] hi8(logic [`ACC_SAMPLE_W-1:0] v);
    return v[`ACC_SAMPLE_W-1 -: 8];
  endfunction

  // low byte of a sample, two lsbs left aligned
  function automatic logic [7:0] lo8(logic [`ACC_SAMPLE_W-1:0] v);
    return {v[`ACC_LO_W-1:0], `ACC_LO_PAD};
  endfunction

  // apply one written byte; locked fields keep their value
  function automatic acc_cfg_t apply_wr(acc_cfg_t c, logic [7:0] a, logic [7:0] d,
                                        logic act);
    acc_cfg_t n;
    n = c;
    if (act) begin
      // only the mode bit and soft reset stay open while active
      if (a == `ACC_A_CTRL1) n.ctrl1[`ACC_B_ACTIVE] = d[`ACC_B_ACTIVE];
      else if (a == `ACC_A_CTRL2) n.ctrl2[`ACC_B_SRST] = d[`ACC_B_SRST];
    end else begin
      // standby only read-only and reserved fall through
      if (a == `ACC_A_FS) n.fs = d;
      else if (a == `ACC_A_CTRL1) n.ctrl1 = d;
      else if (a == `ACC_A_CTRL2) n.ctrl2 = d;
      else if (a == `ACC_A_ORCFG) n.or_cfg = d;
      else if (a == `ACC_A_ORDB) n.or_db = d;
      else if (a == `ACC_A_MDCFG) n.md_cfg = d;
      else if (a == `ACC_A_MDTHS) n.md_ths = d;
      else if (a == `ACC_A_MDDB) n.md_db = d;
      else if (a == `ACC_A_ASLP) n.aslp = d;
      else if (a == `ACC_A_CTRL3) n.ctrl3 = d;
      else if (a == `ACC_A_INTEN) n.inten = d;
      else if (a == `ACC_A_INTMAP) n.intmap = d;
      else if (a == `ACC_A_OFFX) n.offx = d;
      else if (a == `ACC_A_OFFY) n.offy = d;
      else if (a == `ACC_A_OFFZ) n.offz = d;
    end
    return n;
  endfunction

  // read decode; anything not listed is reserved
  function automatic logic [7:0] read_map(logic [7:0] a);
    logic [7:0] r;
    r = `ACC_ZERO; // reserved reads zero
    if (a == `ACC_A_STATUS) r = data_q.status;
    else if (a == `ACC_A_X_HI) r = hi8(data_q.x);
    else if (a == `ACC_A_X_LO) r = lo8(data_q.x);
    else if (a == `ACC_A_Y_HI) r = hi8(data_q.y);
    else if (a == `ACC_A_Y_LO) r = lo8(data_q.y);
    else if (a == `ACC_A_Z_HI) r = hi8(data_q.z);
    else if (a == `ACC_A_Z_LO) r = lo8(data_q.z);
    else if (a == `ACC_A_MODE) r = {`ACC_MODE_PAD, data_q.mode_now};
    else if (a == `ACC_A_INTSRC) r = data_q.int_src;
    else if (a == `ACC_A_IDENT) r = IDENT_CODE;
    else if (a == `ACC_A_FS) r = cfg_q.fs;
    else if (a == `ACC_A_ORIENT) r = data_q.orient;
    else if (a == `ACC_A_ORCFG) r = cfg_q.or_cfg;
    else if (a == `ACC_A_ORDB) r = cfg_q.or_db;
    else if (a == `ACC_A_ZLOCK) r = `ACC_ZLOCK_VAL;
    else if (a == `ACC_A_TRIP) r = `ACC_TRIP_VAL;
    else if (a == `ACC_A_MDCFG) r = cfg_q.md_cfg;
    else if (a == `ACC_A_MDSRC) r = data_q.motion;
    else if (a == `ACC_A_MDTHS) r = cfg_q.md_ths;
    else if (a == `ACC_A_MDDB) r = cfg_q.md_db;
    else if (a == `ACC_A_ASLP) r = cfg_q.aslp;
    else if (a == `ACC_A_CTRL1) r = cfg_q.ctrl1;
    else if (a == `ACC_A_CTRL2) r = cfg_q.ctrl2;
    else if (a == `ACC_A_CTRL3) r = cfg_q.ctrl3;
    else if (a == `ACC_A_INTEN) r = cfg_q.inten;
    else if (a == `ACC_A_INTMAP) r = cfg_q.intmap;
    else if (a == `ACC_A_OFFX) r = cfg_q.offx;
    else if (a == `ACC_A_OFFY) r = cfg_q.offy;
    else if (a == `ACC_A_OFFZ) r = cfg_q.offz;
    return r;
  endfunction

  // -----------------------------------------------------------------
  // bus events and decodes
  // -----------------------------------------------------------------
  wire logic scl_rise = SCL & ~scl_q;
  wire logic scl_fall = ~SCL & scl_q;
  wire logic start_c = scl_q & SCL & sda_q & ~SDA_I; // sda falls, scl high
  wire logic stop_c = scl_q & SCL & ~sda_q & SDA_I; // sda rises, scl high
  wire logic byte_done = scl_fall & (cnt_q == `ACC_BYTE_BITS);
  wire logic act = cfg_q.ctrl1[`ACC_B_ACTIVE];
  wire logic fast = cfg_q.ctrl1[`ACC_B_FREAD];
  wire logic srst = cfg_q.ctrl2[`ACC_B_SRST];
  wire logic shifting = (state_q == ACC_ADDR) | (state_q == ACC_REG) |
                        (state_q == ACC_WDATA);
  wire logic reg_done = (state_q == ACC_REG) & byte_done;
  wire logic wr_fire = (state_q == ACC_WDATA) & byte_done;
  wire logic rd_load = scl_fall & (((state_q == ACC_AACK) & rw_q) |
                                   ((state_q == ACC_MACK) & mack_q));
  wire logic [7:0] rd_byte = read_map(ptr_q);

  // -----------------------------------------------------------------
  // pin sampling
  // -----------------------------------------------------------------
  // previous levels for edge and condition detection
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_o_q <= 1'b0;
    end else begin
      scl_q <= SCL;
      sda_q <= SDA_I;
      sda_o_q <= 1'b0; // open drain only ever pulls low
    end
  end

  // -----------------------------------------------------------------
  // serial slave
  // -----------------------------------------------------------------
  // stop beats everything; a repeated start restarts address phase
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ACC_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      state_q <= ACC_IDLE; // transfer ends, line released
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      state_q <= ACC_ADDR;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      // master data is stable while scl is high
      if (shifting) begin
        sh_q <= {sh_q[6:0], SDA_I};
        cnt_q <= cnt_q + 4'h1;
      end else if (state_q == ACC_RDATA) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (state_q == ACC_MACK) begin
        mack_q <= ~SDA_I;
      end
    end else if (scl_fall) begin
      // sda only changes while scl is low
      case (state_q)
        ACC_ADDR: begin
          if (cnt_q == `ACC_BYTE_BITS) begin
            if (sh_q[7:1] == `ACC_SLAVE_ADDR) begin
              rw_q <= sh_q[0];
              sda_oe_q <= 1'b1;
              state_q <= ACC_AACK;
            end else begin
              state_q <= ACC_IDLE; // other slave addressed
            end
          end
        end
        ACC_AACK, ACC_MACK: begin
          cnt_q <= 4'h0;
          if (rd_load) begin
            // byte at the pointer goes out msb first
            sh_q <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
            state_q <= ACC_RDATA;
          end else if (state_q == ACC_AACK) begin
            sda_oe_q <= 1'b0;
            state_q <= ACC_REG;
          end else begin
            state_q <= ACC_IDLE; // no acknowledge: wait for stop
          end
        end
        ACC_REG: begin
          if (cnt_q == `ACC_BYTE_BITS) begin
            sda_oe_q <= 1'b1;
            state_q <= ACC_RACK;
          end
        end
        ACC_RACK, ACC_WACK: begin
          sda_oe_q <= 1'b0;
          cnt_q <= 4'h0;
          state_q <= ACC_WDATA; // further bytes until stop
        end
        ACC_WDATA: begin
          if (cnt_q == `ACC_BYTE_BITS) begin
            sda_oe_q <= 1'b1; // every byte acknowledged
            state_q <= ACC_WACK;
          end
        end
        ACC_RDATA: begin
          if (cnt_q == `ACC_BYTE_BITS) begin
            sda_oe_q <= 1'b0; // master's acknowledge slot
            state_q <= ACC_MACK;
          end else begin
            sh_q <= {sh_q[6:0], 1'b0};
            sda_oe_q <= ~sh_q[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // register pointer
  // -----------------------------------------------------------------
  // set by the register byte, stepped after every data byte
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ptr_q <= `ACC_A_STATUS;
    end else if (reg_done) begin
      ptr_q <= sh_q;
    end else if (wr_fire || rd_load) begin
      ptr_q <= next_ptr(ptr_q, fast);
    end
  end

  // -----------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------
  // soft reset takes one cycle to land, so its bit is set for one cycle and never reads back
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_q <= CFG_RST;
    end else if (srst) begin
      cfg_q <= CFG_RST;
    end else if (wr_fire) begin
      cfg_q <= apply_wr(cfg_q, ptr_q, sh_q, act);
    end
  end

  // -----------------------------------------------------------------
  // data and event registers
  // -----------------------------------------------------------------
  // cleared on entering active; captures run only while active
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      act_prev_q <= 1'b0;
      data_q <= '0;
    end else begin
      act_prev_q <= act;
      if (act && !act_prev_q) data_q <= '0; // fresh start on standby to active
      else if (act && SENSE_VALID) data_q <= SENSE; // frozen in standby
    end
  end

  assign SDA_OE = sda_oe_q;
  assign SDA_O = sda_o_q;
  assign CFG = cfg_q;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking acc_cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_wr_byte;
    (state_q == ACC_WDATA) && byte_done;
  endsequence

  sequence s_go_active;
    !act_prev_q ##0 act;
  endsequence

  a_wr_advance: assert property (s_wr_byte |=> ptr_q == next_ptr($past(ptr_q), $past(fast)))
    else $error("pointer did not step after a written byte");
  a_wr_ack: assert property (s_wr_byte |=> SDA_OE && state_q == ACC_WACK)
    else $error("written byte not acknowledged");
  a_hi_byte: assert property ((ptr_q == `ACC_A_Y_HI) |-> rd_byte == data_q.y[9:2])
    else $error("high byte does not carry sample msbs");
  a_lo_byte: assert property ((ptr_q == `ACC_A_Z_LO) |-> rd_byte == {data_q.z[1:0], 6'h00})
    else $error("low byte layout wrong");
  a_rsvd_zero: assert property ((ptr_q inside {[8'h07:8'h0a], 8'h0f, [8'h19:8'h28]}) |-> rd_byte == 8'h00)
    else $error("reserved location not zero");
  a_standby_lock: assert property (s_wr_byte ##0 (act && !srst && ptr_q == `ACC_A_OFFX) |=> $stable(cfg_q.offx))
    else $error("configuration changed while active");
  a_clear_active: assert property (s_go_active |=> data_q == '0)
    else $error("data not cleared on entering active");
  a_keep_standby: assert property ($fell(act) |=> $stable(data_q) [*2])
    else $error("data changed on entering standby");
  a_fast_skip: assert property (rd_load && fast && ptr_q == `ACC_A_X_HI |=> ptr_q == `ACC_A_Y_HI)
    else $error("fast read did not skip low byte");
  a_full_order: assert property (rd_load && !fast && ptr_q == `ACC_A_X_LO |=> ptr_q == `ACC_A_Y_HI)
    else $error("normal read order broken");
  a_stop_idle: assert property (stop_c |=> state_q == ACC_IDLE && !SDA_OE)
    else $error("stop did not end the transfer");
  a_wrap_table: assert property (rd_load && ptr_q == `ACC_A_OFFZ |=> ptr_q == `ACC_A_IDENT)
    else $error("last offset did not wrap to identity");
  a_ro_write: assert property (s_wr_byte ##0 (!srst && ptr_q < `ACC_A_FS) |=> $stable(cfg_q))
    else $error("write to read-only location changed configuration");

endmodule

/* File: core/acc_i2c_map.svh */
// Purpose: register offsets, reset values and field positions of the register file
// Assumes: byte-wide registers, 8-bit register pointer
// Notes: definitions only
`ifndef ACC_I2C_MAP_SVH
`define ACC_I2C_MAP_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define ACC_A_STATUS 8'h00
`define ACC_A_X_HI 8'h01
`define ACC_A_X_LO 8'h02
`define ACC_A_Y_HI 8'h03
`define ACC_A_Y_LO 8'h04
`define ACC_A_Z_HI 8'h05
`define ACC_A_Z_LO 8'h06
`define ACC_A_RSVA_LO 8'h07
`define ACC_A_RSVA_HI 8'h0a
`define ACC_A_MODE 8'h0b
`define ACC_A_INTSRC 8'h0c
`define ACC_A_IDENT 8'h0d
`define ACC_A_FS 8'h0e
`define ACC_A_RSVS 8'h0f
`define ACC_A_ORIENT 8'h10
`define ACC_A_ORCFG 8'h11
`define ACC_A_ORDB 8'h12
`define ACC_A_ZLOCK 8'h13
`define ACC_A_TRIP 8'h14
`define ACC_A_MDCFG 8'h15
`define ACC_A_MDSRC 8'h16
`define ACC_A_MDTHS 8'h17
`define ACC_A_MDDB 8'h18
`define ACC_A_RSVB_LO 8'h19
`define ACC_A_RSVB_HI 8'h28
`define ACC_A_ASLP 8'h29
`define ACC_A_CTRL1 8'h2a
`define ACC_A_CTRL2 8'h2b
`define ACC_A_CTRL3 8'h2c
`define ACC_A_INTEN 8'h2d
`define ACC_A_INTMAP 8'h2e
`define ACC_A_OFFX 8'h2f
`define ACC_A_OFFY 8'h30
`define ACC_A_OFFZ 8'h31

// -----------------------------------------------------------------
// reset and fixed values, field positions
// -----------------------------------------------------------------
`define ACC_ZERO 8'h00
`define ACC_ORCFG_RST 8'h80
`define ACC_ZLOCK_VAL 8'h44
`define ACC_TRIP_VAL 8'h84
`define ACC_B_ACTIVE 0
`define ACC_B_FREAD 1
`define ACC_B_SRST 6
`define ACC_SAMPLE_W 10
`define ACC_LO_W 2
`define ACC_LO_PAD 6'h00
`define ACC_MODE_PAD 6'h00
`define ACC_BYTE_BITS 4'h8
`define ACC_SLAVE_ADDR 7'h1d

`endif

/* File: core/acc_pkg.sv */
// Purpose: types shared by the register file and its users
// Assumes: field widths fixed at the documented values
// Notes: values live in acc_i2c_map.svh
package acc_pkg;

  // -----------------------------------------------------------------
  // sensing core results, captured into the read-only data registers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] status;
    logic [9:0] x;
    logic [9:0] y;
    logic [9:0] z;
    logic [1:0] mode_now;
    logic [7:0] int_src;
    logic [7:0] orient;
    logic [7:0] motion;
  } acc_sense_t;

  // -----------------------------------------------------------------
  // software-writable configuration, driven to the sensing core
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] fs;
    logic [7:0] or_cfg;
    logic [7:0] or_db;
    logic [7:0] md_cfg;
    logic [7:0] md_ths;
    logic [7:0] md_db;
    logic [7:0] aslp;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [7:0] inten;
    logic [7:0] intmap;
    logic [7:0] offx;
    logic [7:0] offy;
    logic [7:0] offz;
  } acc_cfg_t;

  // serial slave states
  typedef enum logic [3:0] {
    ACC_IDLE, ACC_ADDR, ACC_AACK, ACC_REG, ACC_RACK,
    ACC_WDATA, ACC_WACK, ACC_RDATA, ACC_MACK
  } acc_state_t;

endpackage

/* File: tb/acc_host_model.sv */
// Purpose: two-wire bus master driving the register file from the host side
// Assumes: open-drain data line with pull-up, resolved in the bench
// Notes: every phase lasts four core clocks (clock-low phases five), well above the design minimum
`timescale 1ns/1ps
module acc_host_model (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // -----------------------------------------------------------------
  // bus primitives
  // -----------------------------------------------------------------
  initial begin
    scl = 1'b1; // bus free: both lines high
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // start or repeated start; data released while the clock is low, pulled low while it is high
  task automatic start_c();
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(1);
  endtask
  // one bit out, line level sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
    scl <= 1'b0;
    tick(1); // keeps the next data change one clock clear of the fall
  endtask
  // byte out msb first, then the slave answer
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r); // released during the answer bit
    ack = ~r;
  endtask
  // byte in; low answer asks for more, high ends the burst
  task automatic recv(output logic [7:0] d, input logic more);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask
  // data rises while the clock is high
  task automatic stop_c();
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
endmodule

/* File: tb/acc_i2c_register_file_tb.sv */
// Purpose: self-checking bench of the register file against a reference register map model
// Assumes: master model on the serial side, random sensing samples
// Notes: reference map held as a byte array indexed by register offset
`timescale 1ns/1ps
`include "acc_i2c_map.svh"
module accel_i2c_register_file_tb import acc_pkg::*;;
  // -----------------------------------------------------------------
  // signals and model state
  // -----------------------------------------------------------------
  logic CORE_CLK, RSTN, SENSE_VALID, SCL, SDA_O, SDA_OE, sda_low, ack_w;
  acc_sense_t SENSE;
  acc_cfg_t CFG;
  wire logic sda_line = ~(SDA_OE | sda_low); // pull-up wins when nobody pulls
  logic [7:0] mreg [0:255]; // reference register map
  logic [7:0] ptr_m; // reference pointer
  logic [7:0] wq [$]; // bytes of the next burst write
  logic [31:0] seed;
  int err_count, total_checks, cyc;
  localparam logic [7:0] ID_VAL = 8'h2b; // arbitrary identity value
  acc_regfile #(.IDENT_CODE(ID_VAL)) uut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .SCL(SCL),
    .SDA_I(sda_line), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SENSE(SENSE),
    .SENSE_VALID(SENSE_VALID), .CFG(CFG));
  acc_host_model m (.clk(CORE_CLK), .sda_in(sda_line), .scl(SCL), .sda_low(sda_low));
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  // -----------------------------------------------------------------
  // reference model
  // -----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] r();
    seed = lfsr(seed);
    return seed[7:0];
  endfunction
  function automatic logic is_rw(input logic [7:0] a);
    return a == 8'h0e || a == 8'h11 || a == 8'h12 || a == 8'h15 || a == 8'h17
      || a == 8'h18 || (a >= 8'h29 && a <= 8'h31);
  endfunction
  function automatic logic is_data(input logic [7:0] a);
    return a <= 8'h06 || a == 8'h0b || a == 8'h0c || a == 8'h10 || a == 8'h16;
  endfunction
  function automatic void cfg_dflt();
    for (int i = 0; i < 256; i++) if (is_rw(i)) mreg[i] = 8'h00;
    mreg[8'h11] = 8'h80;
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] a);
    logic f;
    f = mreg[8'h2a][1];
    if (a == 8'h06 || a > 8'h31) return 8'h00;
    if (a == 8'h31) return 8'h0d;
    if (f && (a == 8'h02 || a == 8'h04 || a == 8'h05)) return 8'h00;
    if (f && (a == 8'h01 || a == 8'h03)) return a + 8'h02;
    return a + 8'h01;
  endfunction
  // write at the pointer: standby-only config, two bits free at any time
  function automatic void mwr(input logic [7:0] d);
    logic was;
    was = mreg[8'h2a][0];
    if (ptr_m == 8'h2b && d[6]) cfg_dflt();
    else if (is_rw(ptr_m) && !was) mreg[ptr_m] = d;
    else if (ptr_m == 8'h2a) mreg[ptr_m][0] = d[0];
    if (!was && mreg[8'h2a][0]) for (int i = 0; i < 256; i++) if (is_data(i)) mreg[i] = 8'h00;
    ptr_m = nxt(ptr_m);
  endfunction
  function automatic acc_cfg_t exp_cfg();
    return {mreg[8'h0e], mreg[8'h11], mreg[8'h12], mreg[8'h15], mreg[8'h17], mreg[8'h18],
      mreg[8'h29], mreg[8'h2a], mreg[8'h2b], mreg[8'h2c], mreg[8'h2d], mreg[8'h2e],
      mreg[8'h2f], mreg[8'h30], mreg[8'h31]};
  endfunction
  // -----------------------------------------------------------------
  // checking and bus tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [119:0] seen, input logic [119:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hdr(input logic [7:0] a);
    m.start_c();
    m.send({`ACC_SLAVE_ADDR, 1'b0}, ack_w);
    chk(ack_w, 1'b1);
    m.send(a, ack_w);
    chk(ack_w, 1'b1);
    ptr_m = a;
  endtask
  task automatic wr(input logic [7:0] a);
    hdr(a);
    foreach (wq[i]) begin
      m.send(wq[i], ack_w);
      chk(ack_w, 1'b1);
      mwr(wq[i]);
    end
    m.stop_c();
    wq.delete();
    chk(CFG, exp_cfg());
    chk(SDA_O, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] d;
    hdr(a);
    m.start_c();
    m.send({`ACC_SLAVE_ADDR, 1'b1}, ack_w);
    chk(ack_w, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.recv(d, i < n - 1);
      chk(d, mreg[ptr_m]);
      ptr_m = nxt(ptr_m);
    end
    m.stop_c();
  endtask
  // random sample; captured only while active
  task automatic sense_pulse();
    acc_sense_t s;
    seed = lfsr(seed);
    s[31:0] = seed;
    seed = lfsr(seed);
    s[63:32] = seed;
    s[71:64] = r();
    SENSE <= s;
    SENSE_VALID <= 1'b1;
    @(posedge CORE_CLK);
    SENSE_VALID <= 1'b0;
    @(posedge CORE_CLK);
    if (mreg[8'h2a][0]) begin
      mreg[0] = s.status;
      mreg[1] = s.x[9:2];
      mreg[2] = {s.x[1:0], 6'h00};
      mreg[3] = s.y[9:2];
      mreg[4] = {s.y[1:0], 6'h00};
      mreg[5] = s.z[9:2];
      mreg[6] = {s.z[1:0], 6'h00};
      mreg[8'h0b] = {6'h00, s.mode_now};
      {mreg[8'h0c], mreg[8'h10], mreg[8'h16]} = {s.int_src, s.orient, s.motion};
    end
  endtask
  // -----------------------------------------------------------------
  // timeout and main sequence
  // -----------------------------------------------------------------
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    RSTN = 1'b0;
    SENSE = '0;
    SENSE_VALID = 1'b0;
    seed = 32'h740e;
    for (int i = 0; i < 256; i++) mreg[i] = 8'h00;
    {mreg[8'h11], mreg[8'h13], mreg[8'h14], mreg[8'h0d]} = {8'h80, 8'h44, 8'h84, ID_VAL};
    repeat (20) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    rd(8'h0d, 9);
    m.start_c();
    m.send(8'h3c, ack_w);
    chk(ack_w, 1'b0); // foreign address left unanswered
    m.stop_c();
    wq = {r(), r(), r()};
    wr(8'h2f);
    rd(8'h2f, 4);
    wq = {r(), r(), r(), r(), r(), r()};
    wr(8'h0c);
    rd(8'h0e, 7);
    wq = {8'h02};
    wr(8'h2a);
    wq = {8'h03};
    wr(8'h2a);
    sense_pulse();
    rd(8'h01, 4);
    wq = {8'h01, r()};
    wr(8'h2a);
    wq = {r()};
    wr(8'h2f);
    wq = {8'h00};
    wr(8'h2a);
    sense_pulse();
    rd(8'h00, 4);
    wq = {8'h00};
    wr(8'h2a);
    wq = {8'h01};
    wr(8'h2a);
    rd(8'h00, 8);
    sense_pulse();
    rd(8'h00, 8);
    rd(8'h0b, 6);
    wq = {8'h40};
    wr(8'h2b);
    rd(8'h16, 1);
    end_sim();
  end
endmodule
